/* File: int_event_pkg.sv */
package int_event_pkg;

  // Byte offsets of the event and mask set/clear pairs
  localparam logic [7:0] EVT_SET_OFF  = 8'h80;
  localparam logic [7:0] EVT_CLR_OFF  = 8'h84;
  localparam logic [7:0] MASK_SET_OFF = 8'h88;
  localparam logic [7:0] MASK_CLR_OFF = 8'h8C;

  // Bit positions in the event and mask words
  localparam int B_LOST   = 22;
  localparam int B_SEC64  = 21;
  localparam int B_SYNCH  = 20;
  localparam int B_PHY    = 19;
  localparam int B_FAIL   = 18;
  localparam int B_BUSRST = 17;
  localparam int B_SID    = 16;
  localparam int B_SID2   = 15;
  localparam int B_LOCK   = 9;
  localparam int B_POST   = 8;
  localparam int B_IRX    = 7;
  localparam int B_ITX    = 6;

  // Latched bits 22..15, 9, 8; mask also covers the two summaries
  localparam logic [31:0] LATCHED_BITS = 32'h007F_8300;
  localparam logic [31:0] MASK_BITS    = 32'h007F_83C0;
  localparam logic [31:0] EVT_RESET    = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET   = 32'h0000_0000;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Event sources from the link core, all on CLK
  typedef struct packed {
    logic cycle_count_lsb;
    logic cycle_sec_bit7;
    logic cycle_start_seen;
    logic subaction_gap;
    logic arb_reset_gap;
    logic phy_status_irq;
    logic reg_access_fail;
    logic phy_bus_reset;
    logic self_id_done;
    logic lock_reply_unacked;
    logic posted_write_fault;
  } link_events_s;

endpackage

/* File: interrupt_event_status_bits.sv */
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
// How it works
// - Two cycle-synchs without cycle start: lost
// - Predict lost: first gap lacks cycle start
// - Predict lost: arbitration reset gap seen
// - Seconds bit seven change sets flag
// - Cycle count LSB toggle sets synch
// - PHY status request sets PHY flag
// - Missing PHY clock access sets flag
// - Failure flag visible before next access
// - PHY bus reset entry sets flag
// - Self-ID stream done sets flag
// - Bus reset clears self-ID done flag
// - Sticky self-ID copy ignores bus reset
// - Bits fourteen to ten read zero
// - Unacked lock reply sets flag
// - Host error on posted write sets flag
// - Receive summary is OR of masked ctx events
// - Transmit summary is OR of masked ctx events
// - Set by timer toggle or bus reset edge, by other sources while high, or by set write
// - Cleared by clear-register write; bus reset also clears self-ID done
// - Clear address reads events AND mask
module interrupt_event_status_bits
  import int_event_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int N_IRX  = 4,
  parameter int N_ITX  = 4
) (
  input  wire logic              CLK,
  input  wire logic              RESET,
  input  wire link_events_s      LINK_EVENTS,
  input  wire logic [N_IRX-1:0]  IRX_CTX_EVENT,
  input  wire logic [N_IRX-1:0]  IRX_CTX_MASK,
  input  wire logic [N_ITX-1:0]  ITX_CTX_EVENT,
  input  wire logic [N_ITX-1:0]  ITX_CTX_MASK,
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY
);

  // Word match on an aligned offset, shared by both channels
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, EVT_SET_OFF) | hit(a, EVT_CLR_OFF)
           | hit(a, MASK_SET_OFF) | hit(a, MASK_CLR_OFF);
  endfunction

  link_events_s      prev_q;
  logic [31:0]       ev_q, ev_d, mask_q, mask_d, hw_set, view;
  logic              armed_q;
  logic              gap_done_q;
  logic              gap_wait_q;
  logic              synch_now, sec_now, busrst_now, lost_now, first_gap;
  logic              irx_sum;
  logic              itx_sum;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic              wr_go;
  logic [31:0]       wmask, wval, sw_set, sw_clr, msk_set, msk_clr;
  logic              rd_take;

  // Edges of the link sources; toggles count both directions
  assign synch_now  = LINK_EVENTS.cycle_count_lsb
                    ^ prev_q.cycle_count_lsb;
  assign sec_now    = LINK_EVENTS.cycle_sec_bit7
                    ^ prev_q.cycle_sec_bit7;
  assign busrst_now = LINK_EVENTS.phy_bus_reset
                    & ~prev_q.phy_bus_reset;

  // Lost cycle: seen, or predicted early from gap timing
  assign first_gap = armed_q & ~gap_done_q
                   & LINK_EVENTS.subaction_gap;
  assign lost_now  = (synch_now & armed_q
                     & ~LINK_EVENTS.cycle_start_seen)
                   | (gap_wait_q
                     & ~LINK_EVENTS.cycle_start_seen)
                   | (armed_q & LINK_EVENTS.arb_reset_gap
                     & ~LINK_EVENTS.cycle_start_seen);

  // Summaries stay unlatched so they track the contexts live
  assign irx_sum = |(IRX_CTX_EVENT & IRX_CTX_MASK);
  assign itx_sum = |(ITX_CTX_EVENT & ITX_CTX_MASK);

  // Hardware set vector, one bit per latched event
  always_comb begin
    hw_set = '0;
    hw_set[B_LOST]   = lost_now;
    hw_set[B_SEC64]  = sec_now;
    hw_set[B_SYNCH]  = synch_now;
    hw_set[B_PHY]    = LINK_EVENTS.phy_status_irq;
    hw_set[B_FAIL]   = LINK_EVENTS.reg_access_fail;
    hw_set[B_BUSRST] = busrst_now;
    hw_set[B_SID]    = LINK_EVENTS.self_id_done;
    hw_set[B_SID2]   = LINK_EVENTS.self_id_done;
    hw_set[B_LOCK]   = LINK_EVENTS.lock_reply_unacked;
    hw_set[B_POST]   = LINK_EVENTS.posted_write_fault;
  end

  // Write decode; strobes gate each byte lane
  assign wr_go = aw_have_q & w_have_q & ~bvalid_q;
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign wmask[8*i+:8] = {8{wstrb_q[i]}};
  end
  assign wval    = wdata_q & wmask;
  assign sw_set  = (wr_go & hit(awaddr_q, EVT_SET_OFF))
                 ? (wval & LATCHED_BITS) : '0;
  assign sw_clr  = (wr_go & hit(awaddr_q, EVT_CLR_OFF))
                 ? (wval & LATCHED_BITS) : '0;
  assign msk_set = (wr_go & hit(awaddr_q, MASK_SET_OFF))
                 ? (wval & MASK_BITS) : '0;
  assign msk_clr = (wr_go & hit(awaddr_q, MASK_CLR_OFF))
                 ? (wval & MASK_BITS) : '0;

  // Hardware set beats a software clear in the same cycle; a bus
  // reset edge still drops the self-ID done bit outright
  assign ev_d = (((ev_q & ~sw_clr) | sw_set | hw_set)
                & LATCHED_BITS)
              & ~(32'(busrst_now) << B_SID);
  assign mask_d = ((mask_q & ~msk_clr) | msk_set) & MASK_BITS;

  // Reads see this cycle's hardware sets so a failed access is
  // already flagged for the access that follows it
  always_comb begin
    view = ((ev_q | hw_set) & LATCHED_BITS)
         & ~(32'(busrst_now) << B_SID);
    view[B_IRX] = irx_sum;
    view[B_ITX] = itx_sum;
  end

  assign rd_take = ARVALID & arready_q;

  // Event, mask and cycle-lost tracking state
  always_ff @(posedge CLK) begin
    if (RESET) begin
      prev_q     <= '0;
      ev_q       <= EVT_RESET;
      mask_q     <= MASK_RESET;
      armed_q    <= 1'b0;
      gap_done_q <= 1'b0;
      gap_wait_q <= 1'b0;
    end else begin
      prev_q     <= LINK_EVENTS;
      ev_q       <= ev_d;
      mask_q     <= mask_d;
      armed_q    <= (armed_q | synch_now)
                  & ~LINK_EVENTS.cycle_start_seen & ~lost_now;
      gap_done_q <= ~synch_now & (gap_done_q | first_gap);
      gap_wait_q <= first_gap & ~LINK_EVENTS.cycle_start_seen;
    end
  end

  // Write channel: address and data taken in either order
  always_ff @(posedge CLK) begin
    if (RESET) begin
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (AWVALID & awready_q) begin
        awaddr_q  <= AWADDR;
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
      end else if (~aw_have_q & ~bvalid_q) begin
        awready_q <= 1'b1;
      end
      if (WVALID & wready_q) begin
        wdata_q  <= WDATA;
        wstrb_q  <= WSTRB;
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
      end else if (~w_have_q & ~bvalid_q) begin
        wready_q <= 1'b1;
      end
      if (wr_go) begin
        bvalid_q  <= 1'b1;
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bresp_q   <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q & BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel: one outstanding read, data latched at accept
  always_ff @(posedge CLK) begin
    if (RESET) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else begin
      if (rd_take) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rresp_q   <= mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
        if (hit(ARADDR, EVT_SET_OFF)) begin
          rdata_q <= view;
        end else if (hit(ARADDR, EVT_CLR_OFF)) begin
          rdata_q <= view & mask_q;
        end else if (mapped(ARADDR)) begin
          rdata_q <= mask_q;
        end else begin
          rdata_q <= '0;
        end
      end else if (rvalid_q & RREADY) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end else if (~rvalid_q) begin
        arready_q <= 1'b1;
      end
    end
  end

  assign AWREADY = awready_q;
  assign WREADY  = wready_q;
  assign BVALID  = bvalid_q;
  assign BRESP   = bresp_q;
  assign ARREADY = arready_q;
  assign RVALID  = rvalid_q;
  assign RDATA   = rdata_q;
  assign RRESP   = rresp_q;

  // Checks on the latched bits and the read path
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  property p_synch;
    synch_now |=> ev_q[B_SYNCH];
  endproperty
  a_synch: assert property (p_synch)
    else $error("synch toggle not latched");

  property p_sec64;
    sec_now |=> ev_q[B_SEC64];
  endproperty
  a_sec64: assert property (p_sec64)
    else $error("seconds bit change not latched");

  property p_lost;
    armed_q && synch_now && !LINK_EVENTS.cycle_start_seen
      |=> ev_q[B_LOST];
  endproperty
  a_lost: assert property (p_lost)
    else $error("lost cycle not flagged");

  property p_phy;
    LINK_EVENTS.phy_status_irq |=> ev_q[B_PHY];
  endproperty
  a_phy: assert property (p_phy)
    else $error("PHY request not latched");

  property p_fail;
    LINK_EVENTS.reg_access_fail |-> view[B_FAIL] ##1 ev_q[B_FAIL];
  endproperty
  a_fail: assert property (p_fail)
    else $error("access failure not visible");

  property p_busrst;
    busrst_now |=> ev_q[B_BUSRST] && !ev_q[B_SID];
  endproperty
  a_busrst: assert property (p_busrst)
    else $error("bus reset did not drop self-ID");

  property p_sid;
    LINK_EVENTS.self_id_done && !busrst_now
      |=> ev_q[B_SID] && ev_q[B_SID2];
  endproperty
  a_sid: assert property (p_sid)
    else $error("self-ID pair not set");

  property p_sticky;
    ev_q[B_SID2] && !sw_clr[B_SID2] |=> ev_q[B_SID2];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("event bit lost without clear");

  property p_rsvd;
    RVALID |-> RDATA[14:10] == 5'h00;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits read nonzero");

  property p_masked;
    rd_take && hit(ARADDR, EVT_CLR_OFF)
      |=> (RDATA & ~$past(mask_q)) == 32'h0000_0000;
  endproperty
  a_masked: assert property (p_masked)
    else $error("clear-address read not masked");

  c_write: cover property (wr_go && hit(awaddr_q, EVT_CLR_OFF));
  c_read:  cover property (RVALID && RREADY && RDATA != '0);
  c_lost:  cover property (lost_now && !synch_now);
  c_busid: cover property (busrst_now && LINK_EVENTS.self_id_done);

endmodule

/* File: link_side_model.sv */
`timescale 1ns/10ps
module link_side_model
  import int_event_pkg::*;
(
  input  wire logic    clk,
  output link_events_s link_events,
  output logic [3:0]   irx_event,
  output logic [3:0]   irx_mask,
  output logic [3:0]   itx_event,
  output logic [3:0]   itx_mask
);
  // Timer bits and bus-reset are levels that toggle; the rest are one-cycle strobes
  localparam logic [10:0] LEVELS = 11'h608;

  // Quiet link at time zero
  initial begin
    link_events = link_events_s'(11'h000);
    set_ctx(4'h0, 4'h0, 4'h0, 4'h0);
  end

  // Strobes last one cycle so a held line never sets a flag twice
  task automatic fire(input logic [10:0] s);
    logic [10:0] lv;
    lv = (11'(link_events) ^ s) & LEVELS;
    @(posedge clk);
    link_events <= link_events_s'(lv | (s & ~LEVELS));
    @(posedge clk);
    link_events <= link_events_s'(lv);
  endtask

  // Per-context isochronous event and mask levels
  task automatic set_ctx(input logic [3:0] re, rm, te, tm);
    irx_event <= re;
    irx_mask  <= rm;
    itx_event <= te;
    itx_mask  <= tm;
  endtask
endmodule

/* File: interrupt_event_status_bits_tb.sv */
`timescale 1ns/10ps
module interrupt_event_status_bits_tb
  import int_event_pkg::*;
;
  logic         clk = 1'b0;
  logic         reset = 1'b1;
  logic [7:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata;
  logic [3:0]   wstrb, irx_e, irx_m, itx_e, itx_m;
  logic         awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready;
  logic [1:0]   bresp, rresp;
  link_events_s events;
  int           mismatches = 0;
  int           comparisons = 0;
  int           cycles = 0;

  link_side_model partner (.clk(clk), .link_events(events), .irx_event(irx_e),
    .irx_mask(irx_m), .itx_event(itx_e), .itx_mask(itx_m));

  interrupt_event_status_bits dut (.CLK(clk), .RESET(reset), .LINK_EVENTS(events),
    .IRX_CTX_EVENT(irx_e), .IRX_CTX_MASK(irx_m), .ITX_CTX_EVENT(itx_e),
    .ITX_CTX_MASK(itx_m), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));

  // Free-running 50 MHz clock
  always #10 clk = ~clk;

  // Watchdog: whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  // Address and data offered together, each dropped once taken; waits for B
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(d, exp, what);
  endtask

  // Clearing all latched flags gives each scenario a known start
  task automatic clr();
    logic [1:0] r;
    wr(EVT_CLR_OFF, 32'hFFFF_FFFF, 4'hF, r);
  endtask

  task automatic t_regs();
    logic [1:0]  r;
    logic [31:0] d;
    rd_chk(EVT_SET_OFF, EVT_RESET, "event reset");
    rd_chk(MASK_SET_OFF, MASK_RESET, "mask reset");
    wr(EVT_SET_OFF, 32'hFFFF_FFFF, 4'hF, r);
    check({30'h0, r}, {30'h0, RESP_OKAY}, "set resp");
    rd_chk(EVT_SET_OFF, 32'h007F_8300, "set all");
    wr(EVT_CLR_OFF, 32'h0000_0000, 4'hF, r);
    rd_chk(EVT_SET_OFF, 32'h007F_8300, "zero clear");
    wr(MASK_SET_OFF, 32'h0000_0100, 4'hF, r);
    rd_chk(EVT_CLR_OFF, 32'h0000_0100, "masked read");
    wr(EVT_CLR_OFF, 32'hFFFF_FFFF, 4'hD, r);
    rd_chk(EVT_SET_OFF, 32'h0000_8300, "strobed clear");
    wr(MASK_CLR_OFF, 32'hFFFF_FFFF, 4'hF, r);
    rd_chk(MASK_SET_OFF, 32'h0000_0000, "mask clear");
    wr(8'h90, 32'hFFFF_FFFF, 4'hF, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    rd(8'h90, d, r);
    check(d, 32'h0000_0000, "unmapped data");
    check({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
    clr();
    $display("t_regs done");
  endtask

  task automatic t_sources();
    logic [10:0] src[4] = '{11'h020, 11'h010, 11'h002, 11'h001};
    int          pos[4] = '{B_PHY, B_FAIL, B_LOCK, B_POST};
    for (int i = 0; i < 4; i++) begin
      clr();
      partner.fire(src[i]);
      rd_chk(EVT_SET_OFF, 32'h1 << pos[i], "source");
    end
    clr();
    partner.fire(11'h004);
    rd_chk(EVT_SET_OFF, 32'h0001_8000, "self id");
    partner.fire(11'h008);
    rd_chk(EVT_SET_OFF, 32'h0002_8000, "bus reset");
    partner.fire(11'h008);
    clr();
    $display("t_sources done");
  endtask

  // Second event after a synch: another synch, an arbitration gap, a bare gap
  task automatic t_timer();
    logic [10:0] nxt[3] = '{11'h400, 11'h040, 11'h080};
    partner.fire(11'h200);
    rd_chk(EVT_SET_OFF, 32'h1 << B_SEC64, "seconds");
    clr();
    partner.fire(11'h400);
    rd_chk(EVT_SET_OFF, 32'h1 << B_SYNCH, "synch");
    partner.fire(11'h100);
    partner.fire(11'h400);
    partner.fire(11'h100);
    rd_chk(EVT_SET_OFF, 32'h1 << B_SYNCH, "start kept cycle");
    for (int i = 0; i < 3; i++) begin
      clr();
      partner.fire(11'h400);
      partner.fire(nxt[i]);
      rd_chk(EVT_SET_OFF, 32'h0050_0000, "lost");
      partner.fire(11'h100);
    end
    clr();
    $display("t_timer done");
  endtask

  task automatic t_summary();
    logic [1:0] r;
    partner.set_ctx(4'h1, 4'h1, 4'h0, 4'h0);
    rd_chk(EVT_SET_OFF, 32'h0000_0080, "rx summary");
    partner.set_ctx(4'h0, 4'h0, 4'h8, 4'h8);
    rd_chk(EVT_SET_OFF, 32'h0000_0040, "tx summary");
    partner.set_ctx(4'h0, 4'h0, 4'h0, 4'h0);
    wr(EVT_SET_OFF, 32'h0000_7CC0, 4'hF, r);
    rd_chk(EVT_SET_OFF, 32'h0000_0000, "ignored bits");
    $display("t_summary done");
  endtask

  // Reset for eight cycles, then the scenarios in turn
  initial begin
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_sources();
    t_timer();
    t_summary();
    complete_run();
  end
endmodule
